// file: prescaler_divider.sv
/*
 holds the pre-divider: a toggling counter giving div 1, 2 or 4 enables.
 assumes reserved code 3 is treated as divide by 4.
*/
`timescale 1ns/1ps
`include "sysref_request_control_regs.svh"
module prescaler_divider
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic enable,
  input wire logic [1:0] sel,
  output logic tick
);
  logic [1:0] count_reg;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      count_reg <= 2'h0;
    else if (clear || !enable)
      count_reg <= 2'h0;
    else
      count_reg <= count_reg + 2'h1;
  end
  always_comb
  begin
    case (sel)
      `PRE_DIV1: tick = enable;
      `PRE_DIV2: tick = enable && count_reg[0];
      default: tick = enable && (count_reg == 2'h3);
    endcase
  end
endmodule

// file: request_delay_line.sv
/*
 holds a tap delay line: the request is delayed by taps clock cycles.
 assumes taps in unit steps of one clock; clear empties the line.
*/
`timescale 1ns/1ps
`include "sysref_request_control_regs.svh"
module request_delay_line
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic [5:0] taps,
  input wire logic din,
  output logic dout
);
  logic [63:0] line_reg;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      line_reg <= 64'h0;
    else if (clear)
      line_reg <= 64'h0;
    else
      line_reg <= {line_reg[62:0], din};
  end
  // tap zero passes straight through
  always_comb
  begin
    if (taps == 6'h0)
      dout = din;
    else
      dout = line_reg[taps - 6'h1];
  end
endmodule

// file: sysref_request_control.sv
/*
 holds the request control register bank with its axi4-lite slave, the
 request path, the subsystem enables and the pre-divider tick.
 assumes request_pin is asynchronous and a 25 MHz clock; one access of
 each kind at a time.
*/
// Function
// - control register at offset 0xf, resets to 0x0901
// - bits 11:10 select divide 1, 2, 4; code 3 reserved; reset 0x2
// - bit 7 enables sysref, and sync too in sync pin function
// - enable low disables sysref, and sync and capture unless sync path enable set
// - sync path enable keeps sync path and capture alive regardless
// - bits 6:1 delay the request by taps times unit step
// - in repeater mode delay taps delay the repeated sysref
// - clear bit resets latch, divider retimers and capture flops
// - clear set forces internal request low except in repeater mode
// - pin function 0 is sync input, 1 is sysref request input
// - latch holds request high after first rising edge until clear or until the request path is switched off
`timescale 1ns/1ps
`include "sysref_request_control_regs.svh"
module sysref_request_control
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic request_pin,
  output logic request_out,
  output logic prescaler_tick,
  output sysref_request_control_pkg::enables_type enables,
  output logic retimer_clear,
  output logic capture_clear
);
  import sysref_request_control_pkg::*;

  typedef enum logic [1:0]
  {
    wr_idle_type = 2'b00,
    wr_resp_type = 2'b01
  } wr_state_type;

  ctrl_type ctrl_reg;
  logic [7:0] mode_reg;
  wr_state_type wr_state_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] pin_sync_reg;
  logic pin_prev_reg;
  logic latch_reg;
  logic delayed;
  logic tick;
  logic do_write;
  logic [15:0] ctrl_word;
  logic [15:0] ctrl_next;
  logic sync_mode;
  logic repeat_mode;
  logic path_on;
  logic raw_req;
  logic req_next;
  enables_type enables_next;

  assign ctrl_word = {4'h0, ctrl_reg};
  assign sync_mode = (mode_reg[`MODE_PIN_BIT] == `PIN_SYNC);
  assign repeat_mode = mode_reg[`MODE_REPEAT_BIT];
  // a word is written only once both halves were taken with their ready
  assign do_write = (wr_state_reg == wr_idle_type) &&
    aw_held_reg && w_held_reg;

  // write address and data may arrive in either order
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h0;
    end
    else if (do_write)
      aw_held_reg <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end
    else if (do_write)
      w_held_reg <= 1'b0;
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end
  end

  // ready stays low while a word is held or a response is pending
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !s_axi_awready && !aw_held_reg && !do_write &&
        (wr_state_reg == wr_idle_type) && s_axi_awvalid;
      s_axi_wready <= !s_axi_wready && !w_held_reg && !do_write &&
        (wr_state_reg == wr_idle_type) && s_axi_wvalid;
    end
  end

  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  assign wa = awaddr_reg;
  assign wd = wdata_reg;
  assign ws = wstrb_reg;

  // byte-lane merge; bits 15:12 are never stored
  always_comb
  begin
    ctrl_next = ctrl_word;
    if (ws[0])
      ctrl_next[7:0] = wd[7:0];
    if (ws[1])
      ctrl_next[15:8] = wd[15:8];
    ctrl_next = ctrl_next & `CTRL_WMASK;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctrl_reg <= 12'(`CTRL_RESET);
    else if (do_write && (wa == `CTRL_ADDR))
      ctrl_reg <= ctrl_next[11:0];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      mode_reg <= `MODE_RESET;
    else if (do_write && (wa == `MODE_ADDR) && ws[0])
      mode_reg <= {3'h0, wd[4:0]};
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_state_reg <= wr_idle_type;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else if (do_write)
    begin
      wr_state_reg <= wr_resp_type;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= ((wa == `CTRL_ADDR) || (wa == `MODE_ADDR) ||
        (wa == `STATUS_ADDR)) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      wr_state_reg <= wr_idle_type;
      s_axi_bvalid <= 1'b0;
    end
  end

  // read: arready pulses one cycle, data follows on the next edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      case (s_axi_araddr)
        `CTRL_ADDR: s_axi_rdata <= {16'h0, ctrl_word};
        `MODE_ADDR: s_axi_rdata <= {24'h0, mode_reg};
        `STATUS_ADDR: s_axi_rdata <= {27'h0, latch_reg, request_out,
          enables};
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else
      s_axi_arready <= s_axi_arvalid;
  end

  // subsystem enables
  always_comb
  begin
    enables_next.subsystem_on = ctrl_reg.subsystem_enable;
    enables_next.sync_path_on = (ctrl_reg.subsystem_enable && sync_mode) ||
      mode_reg[`MODE_SYNCEN_BIT];
    enables_next.capture_on = ctrl_reg.subsystem_enable ||
      mode_reg[`MODE_SYNCEN_BIT];
  end
  assign path_on = enables_next.subsystem_on || enables_next.sync_path_on;

  // two flops before the pin is looked at
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pin_sync_reg <= 2'h0;
    else
      pin_sync_reg <= {pin_sync_reg[0], request_pin};
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pin_prev_reg <= 1'b0;
    else
      pin_prev_reg <= delayed;
  end

  // the edge is detected after the delay so taps shift the latch moment
  request_delay_line u_request_delay_line
  (
    .clk(clk),
    .resetn(resetn),
    .clear(ctrl_reg.request_clear && !repeat_mode),
    .taps(ctrl_reg.request_delay_taps),
    .din(pin_sync_reg[1] || mode_reg[`MODE_SOFT_BIT]),
    .dout(delayed)
  );

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      latch_reg <= 1'b0;
    else if (ctrl_reg.request_clear || !path_on)
      latch_reg <= 1'b0;
    // rising edge only: a level already high at enable is not latched
    else if (mode_reg[`MODE_LATCH_BIT] && delayed && !pin_prev_reg)
      latch_reg <= 1'b1;
  end

  always_comb
  begin
    raw_req = mode_reg[`MODE_LATCH_BIT] ? (latch_reg || delayed) : delayed;
    if (!path_on)
      req_next = 1'b0;
    else if (ctrl_reg.request_clear && !repeat_mode)
      req_next = 1'b0;
    else
      req_next = raw_req;
  end

  prescaler_divider u_prescaler_divider
  (
    .clk(clk),
    .resetn(resetn),
    .clear(ctrl_reg.request_clear),
    .enable(enables_next.subsystem_on),
    .sel(ctrl_reg.prescaler_select),
    .tick(tick)
  );

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      request_out <= 1'b0;
      prescaler_tick <= 1'b0;
      enables <= '0;
      retimer_clear <= 1'b1;
      capture_clear <= 1'b1;
    end
    else
    begin
      request_out <= req_next;
      prescaler_tick <= tick;
      enables <= enables_next;
      retimer_clear <= ctrl_reg.request_clear;
      capture_clear <= ctrl_reg.request_clear || !enables_next.capture_on;
    end
  end
endmodule

// file: sysref_request_control_pkg.sv
/*
 holds the types shared by the request control files.
 assumes nothing beyond a systemverilog compiler.
*/
package sysref_request_control_pkg;
  typedef struct packed {
    logic [1:0] prescaler_select;
    logic [1:0] reserved_field;
    logic subsystem_enable;
    logic [5:0] request_delay_taps;
    logic request_clear;
  } ctrl_type;
  typedef struct packed {
    logic subsystem_on;
    logic sync_path_on;
    logic capture_on;
  } enables_type;
endpackage

// file: sysref_request_control_properties.sv
/*
 port assertions for the request control block.
 assumes it is bound to the top module; one clock domain.
*/
`timescale 1ns/1ps
module sysref_request_control_properties
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic request_out,
  input wire logic prescaler_tick,
  input wire sysref_request_control_pkg::enables_type enables,
  input wire logic retimer_clear,
  input wire logic capture_clear
);
  import sysref_request_control_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped early");
  AST_W_ANSWER:
    assert property (s_axi_awready |-> ##[0:3] s_axi_bvalid)
    else $error("no write answer");
  AST_R_ANSWER:
    assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  AST_RSV_ZERO:
    assert property (s_axi_arready && s_axi_araddr == 8'h3c
      |=> s_axi_rdata[15:12] == 4'h0)
    else $error("reserved bits not zero");
  AST_UNMAPPED:
    assert property (s_axi_arready && s_axi_araddr == 8'h08
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read accepted");
  AST_CLEARS_TIED:
    assert property (capture_clear == (retimer_clear || !enables.capture_on))
    else $error("capture clear not tied to clear and enable");
  AST_RESET_STATE:
    assert property ($rose(resetn) |-> retimer_clear && !request_out
      && enables == 3'h0)
    else $error("bad state after reset");
  // three cycles of margin for the tick counter lag
  AST_TICK_OFF:
    assert property (!enables.subsystem_on [*3] |-> !prescaler_tick)
    else $error("tick while disabled");
  AST_CAPTURE_GATE:
    assert property (enables.capture_on
      |-> enables.subsystem_on || enables.sync_path_on)
    else $error("capture without enable");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (prescaler_tick ##1 prescaler_tick);
  cover property ($fell(retimer_clear));
  cover property ($rose(request_out));
endmodule
bind sysref_request_control sysref_request_control_properties u_props (
  .clk, .resetn, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .request_out, .prescaler_tick,
  .enables, .retimer_clear, .capture_clear);

// file: sysref_request_control_regs.svh
/*
 holds the register offsets, field positions, reset values and codes of the
 request control block. assumes it is included by its bare name.
*/
`ifndef SYSREF_REQUEST_CONTROL_REGS_SVH
`define SYSREF_REQUEST_CONTROL_REGS_SVH
`define CTRL_INDEX 4'hf
`define CTRL_ADDR 8'h3c
`define MODE_ADDR 8'h40
`define STATUS_ADDR 8'h44
`define CTRL_RESET 16'h0901
`define CTRL_WMASK 16'h0fff
`define PRE_HI 11
`define PRE_LO 10
`define RSV_HI 9
`define RSV_LO 8
`define EN_BIT 7
`define TAPS_HI 6
`define TAPS_LO 1
`define CLR_BIT 0
`define PRE_DIV1 2'h0
`define PRE_DIV2 2'h1
`define PRE_DIV4 2'h2
`define PIN_SYNC 1'h0
`define PIN_REQ 1'h1
`define MODE_RESET 8'h02
`define MODE_LATCH_BIT 0
`define MODE_PIN_BIT 1
`define MODE_SYNCEN_BIT 2
`define MODE_REPEAT_BIT 3
`define MODE_SOFT_BIT 4
`define TAP_MAX 6'h3f
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: tb_sysref_request_control.sv
/*
 self-checking bench for the request control block.
 assumes the design and the checker are compiled first.
*/
`timescale 1ns/1ps
module tb_sysref_request_control;
  import sysref_request_control_pkg::*;
  logic clk = 1'b0;
  logic resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, request_pin, request_out;
  logic prescaler_tick, retimer_clear, capture_clear;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, n, m, bad_count, num_checks;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  enables_type enables;
  // address, write data, read back, response
  logic [41:0] rows [4] = '{{8'h3c, 16'hf5ff, 16'h05ff, 2'h0},
    {8'h3c, 16'h0500, 16'h0500, 2'h0}, {8'h40, 16'h1f, 16'h1f, 2'h0},
    {8'h08, 16'h1234, 16'h0, 2'h2}};
  sysref_request_control u_sysref_request_control (.clk, .resetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .request_pin, .request_out, .prescaler_tick,
    .enables, .retimer_clear, .capture_clear);
  always #20 clk = ~clk;
  task automatic chk(input string s, input logic [31:0] v, e);
    num_checks = num_checks + 1;
    if (v !== e)
    begin
      bad_count = bad_count + 1;
      $display("Error %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // nonblocking drives after the rising edge keep awvalid from being set twice in one step
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk);
  endtask
  task automatic wt(input logic v);
    n = 0;
    while (request_out !== v && n < 20)
    begin
      @(posedge clk);
      n = n + 1;
    end
    chk("request", request_out, v);
  endtask
  task automatic lat(output logic [31:0] t);
    t = 0;
    request_pin <= 1'b1;
    while (request_out !== 1'b1 && t < 99)
    begin
      @(posedge clk);
      t = t + 1;
    end
    request_pin <= 1'b0;
    repeat (80) @(posedge clk);
  endtask
  task automatic rst;
    resetn <= 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("reset", {retimer_clear, capture_clear, request_out, enables},
      6'h30);
    rd(8'h3c);
    chk("ctrl", d, 32'h0901);
    rd(8'h40);
    chk("mode", d, 32'h02);
  endtask
  initial
  begin
    #800000;
    bad_count = bad_count + 1;
    stop_test();
  end
  initial
  begin
    bad_count = 0;
    num_checks = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, request_pin} <= 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} <= 18'h0;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'hf;
    rst();
    foreach (rows[i])
    begin
      wr(rows[i][41:34], rows[i][33:18]);
      chk("bresp", r, rows[i][1:0]);
      rd(rows[i][41:34]);
      chk("rdata", d, rows[i][17:2]);
      chk("rresp", r, rows[i][1:0]);
    end
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h40, {13'h0, i[2], i[1], 1'b0});
      wr(8'h3c, {8'h09, i[0], 7'h0});
      repeat (3) @(posedge clk);
      chk("enables", enables,
        {i[0], i[2] | i[0] & ~i[1], i[0] | i[2]});
    end
    wr(8'h40, 16'h02);
    for (int c = 0; c < 5; c++)
    begin
      wr(8'h3c, {4'h0, c[1:0], 2'h1, c < 4 ? 8'h80 : 8'h00});
      repeat (4) @(posedge clk);
      n = 0;
      repeat (16)
      begin
        @(posedge clk);
        n = n + prescaler_tick;
      end
      chk("ticks", n, c == 4 ? 0 : c == 3 ? 4 : 16 >> c);
    end
    for (int b = 0; b < 2; b++)
    begin
      wr(8'h3c, {15'h04c0, b[0]});
      repeat (3) @(posedge clk);
      chk("clears", {retimer_clear, capture_clear}, {2{b[0]}});
    end
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h40, i ? 16'h0a : 16'h02);
      wr(8'h3c, 16'h0980);
      lat(n);
      wr(8'h3c, 16'h09fe);
      lat(m);
      chk("delay", m - n, 63);
    end
    wr(8'h40, 16'h12);
    wr(8'h3c, 16'h0981);
    repeat (10) @(posedge clk);
    chk("soft", request_out, 1'b0);
    wr(8'h3c, 16'h0980);
    wt(1'b1);
    wr(8'h40, 16'h03);
    wt(1'b0);
    request_pin <= 1'b1;
    wt(1'b1);
    request_pin <= 1'b0;
    repeat (10) @(posedge clk);
    chk("latch", request_out, 1'b1);
    rd(8'h44);
    chk("status", d, 32'h1d);
    wr(8'h3c, 16'h0981);
    wt(1'b0);
    wr(8'h3c, 16'h0980);
    repeat (10) @(posedge clk);
    chk("latch", request_out, 1'b0);
    wr(8'h40, 16'h0a);
    wr(8'h3c, 16'h0981);
    request_pin <= 1'b1;
    wt(1'b1);
    request_pin <= 1'b0;
    rst();
    stop_test();
  end
endmodule
